// File: uem_consts.svh
/*
 Register offsets, field positions, reset values and mode encodings of the
 endpoint mode engine. Assumes inclusion by bare name from design files.
*/
`ifndef UEM_CONSTS_SVH
`define UEM_CONSTS_SVH

// ==========================================================
// Register offsets
`define UEM_ADDR_ENABLE 8'h40
`define UEM_ADDR_CNT0 8'h41
`define UEM_ADDR_CNT1 8'h42
`define UEM_ADDR_CNT2 8'h43
`define UEM_ADDR_MODE0 8'h44
`define UEM_ADDR_MODE1 8'h45
`define UEM_ADDR_MODE2 8'h46
`define UEM_ADDR_BUF0 8'h50
`define UEM_ADDR_BUF1 8'h58
`define UEM_ADDR_BUF2 8'h60
`define UEM_BUF_DEPTH 8

// ==========================================================
// Field positions
`define UEM_CNT_TOG 7
`define UEM_CNT_VALID 6
`define UEM_MODE_SETUP 7
`define UEM_MODE_IN 6
`define UEM_MODE_OUT 5
`define UEM_MODE_ACKD 4
`define UEM_MODE_STALL 7
`define UEM_MODE_NAKIE 5
`define UEM_REG_RESET 8'h00

// ==========================================================
// Mode encodings
`define UEM_M_DISABLE 4'h0
`define UEM_M_NAKIO 4'h1
`define UEM_M_STOUT 4'h2
`define UEM_M_STALLIO 4'h3
`define UEM_M_STIN 4'h6
`define UEM_M_ACKOUT_STIN 4'hB
`define UEM_M_ACKIN_STOUT 4'hF
`define UEM_M_NAKOUT 4'h8
`define UEM_M_ACKOUT 4'h9
`define UEM_M_NAKIN 4'hC
`define UEM_M_ACKIN 4'hD
`define UEM_CTRL_MAX 4'hA
`define UEM_STATUS_LEN 4'h2

`endif

// File: uem_engine.sv
/*
 Endpoint mode engine: decides the handshake for each token and updates the
 endpoint mode and count registers, with three 8-byte endpoint buffers.
 Assumes a packet layer that decodes tokens and checks CRC, that delivers
 each data byte before the matching token/packet summary, and that reports
 whether the host ACKed transmitted IN data.
*/
// Chosen here: the strobed register port.
// Functional notes
// RULE1: Control SETUP up to ten bytes valid: ACK, set flags, store, mode 0001.
// RULE2: Control mode 0011: STALL IN and valid OUT, registers unchanged.
// RULE3: Control mode 0001: NAK IN and valid OUT, registers unchanged.
// RULE4: Control 1111 IN: send count; on host ACK set flags, mode 0001.
// RULE5: Control 1111 OUT count 2 toggle 1: ACK, flags, count, mode 0010.
// RULE6: Control 1111/0010 bad status OUT: STALL, mode 0011, interrupt.
// RULE7: Control 0010 IN: STALL, mode 0011, interrupt.
// RULE8: Control 0010 good status OUT: ACK, flags, count 2, mode kept.
// RULE9: Control 1011/0110 IN: zero-length data; on ACK flags, mode 0011.
// RULE10: Control 1011 valid OUT: ACK, store, flags, count, mode 0001.
// RULE11: Control 0110 valid OUT: STALL, mode 0011, interrupt.
// RULE12: Data OUT too long or invalid: no handshake, registers unchanged.
// RULE13: Data 1001 stall clear valid OUT: ACK, store, count, mode 1000.
// RULE14: Data 1001 stall set valid OUT: STALL, nothing else changes.
// RULE15: Data 1000/1100: NAK; interrupt only if NAK interrupt enabled.
// RULE16: Data 1101 stall clear IN: send count; on ACK flag, mode 1100.
// RULE17: Data 1101 stall set: STALL IN, ignore OUT.
// RULE18: Count register: toggle bit 7, valid bit 6, count bits 3:0.
// RULE19: Firmware write to control mode clears its four flag bits.
// RULE20: Status check ACKs only toggle 1 packets of expected length.
// RULE21: Without host ACK of IN data nothing changes, data resent.
`timescale 1ns/1ps
`include "uem_consts.svh"

module uem_engine #(
   parameter int MAX_DATA = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata,
   // Packet layer
   input wire uem_pkg::uem_tok_s tokIn,
   input wire uem_pkg::uem_byte_s byteIn,
   input wire logic hostAck,
   output uem_pkg::uem_resp_s respOut,
   // Status
   output logic usbEnable,
   output logic [6:0] devAddr,
   output logic [2:0] epIrq
);
   import uem_pkg::*;

   initial begin
      if (MAX_DATA < 1 || MAX_DATA > `UEM_BUF_DEPTH) begin
         $error("MAX_DATA out of range");
      end
   end

   // ==========================================================
   // Reset release
   logic rstSync1_reg, rstN_reg;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rstSync1_reg <= 1'b0;
         rstN_reg <= 1'b0;
      end else begin
         rstSync1_reg <= 1'b1;
         rstN_reg <= rstSync1_reg;
      end
   end

   // ==========================================================
   // Registers
   logic [7:0] enable_reg;
   logic [7:0] cnt_reg [3];
   logic [7:0] mode_reg [3];
   logic [7:0] buf_reg [3][`UEM_BUF_DEPTH];
   logic [7:0] cnt_next [3];
   logic [7:0] mode_next [3];
   logic [2:0] irq_next;
   uem_resp_s resp_next;
   // Pending IN transmission waiting on the host's ACK.
   logic pendValid_reg, pendValid_next;
   logic [1:0] pendEp_reg, pendEp_next;

   // ==========================================================
   // Decode
   wire logic [1:0] ep = tokIn.endp;
   wire logic epOk = (ep != 2'd3) && enable_reg[7];
   wire logic [7:0] curMode = (ep == 2'd3) ? 8'h00 : mode_reg[ep];
   wire logic [7:0] curCnt = (ep == 2'd3) ? 8'h00 : cnt_reg[ep];
   wire logic [3:0] mode = curMode[3:0];
   wire logic isSetup = tokIn.valid && epOk && tokIn.kind == UEM_TOK_SETUP;
   wire logic isIn = tokIn.valid && epOk && tokIn.kind == UEM_TOK_IN;
   wire logic isOut = tokIn.valid && epOk && tokIn.kind == UEM_TOK_OUT;
   wire logic ctrlOk = tokIn.dataOk && tokIn.count <= `UEM_CTRL_MAX;
   wire logic dataLenOk = tokIn.dataOk &&
      tokIn.count <= 4'(MAX_DATA);
   wire logic goodStatus = tokIn.count == `UEM_STATUS_LEN && tokIn.toggle;
   wire logic stallBit = curMode[`UEM_MODE_STALL];
   wire logic nakIe = curMode[`UEM_MODE_NAKIE];
   wire logic bufWrEn = byteIn.valid && tokIn.endp != 2'd3;
   wire logic [7:0] cntUpd = {tokIn.toggle, 1'b1, 2'b00, tokIn.count};
   wire logic [7:0] fwBufOff = regAddr - `UEM_ADDR_BUF0;
   wire logic [1:0] fwBufEp = fwBufOff[4:3];
   wire logic fwBufHit = regAddr >= `UEM_ADDR_BUF0 &&
      regAddr < `UEM_ADDR_BUF2 + 8'(`UEM_BUF_DEPTH);

   // ==========================================================
   // Response decision
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         cnt_next[i] = cnt_reg[i];
         mode_next[i] = mode_reg[i];
      end
      irq_next = 3'b000;
      resp_next = '0;
      pendValid_next = pendValid_reg;
      pendEp_next = pendEp_reg;
      if (pendValid_reg && hostAck) begin
         pendValid_next = 1'b0;
         irq_next[pendEp_reg] = 1'b1;
         if (pendEp_reg == 2'd0) begin
            mode_next[0][`UEM_MODE_IN] = 1'b1;
            mode_next[0][`UEM_MODE_ACKD] = 1'b1;
            mode_next[0][3:0] = (mode_reg[0][3:0] == `UEM_M_ACKIN_STOUT) ?
               `UEM_M_NAKIO : `UEM_M_STALLIO; // [RULE4] [RULE9]
         end else begin
            mode_next[pendEp_reg][`UEM_MODE_ACKD] = 1'b1;
            mode_next[pendEp_reg][3:0] = `UEM_M_NAKIN; // [RULE16]
         end
      end else if (tokIn.valid) begin
         // A new token without host ACK drops the pending IN. [RULE21]
         pendValid_next = 1'b0;
      end
      if (tokIn.valid && epOk && ep == 2'd0 &&
            mode != `UEM_M_DISABLE) begin
         if (isSetup && ctrlOk) begin
            resp_next = '{1'b1, UEM_HS_ACK, 4'h0, 1'b0};
            mode_next[0] = {1'b1, 2'b00, 1'b1, `UEM_M_NAKIO}; // [RULE1]
            cnt_next[0] = cntUpd; // [RULE18]
            irq_next[0] = 1'b1;
         end else if (isIn) begin
            case (mode)
               `UEM_M_STALLIO: resp_next.hs = UEM_HS_STALL; // [RULE2]
               `UEM_M_NAKIO: resp_next.hs = UEM_HS_NAK; // [RULE3]
               `UEM_M_STOUT: begin
                  resp_next.hs = UEM_HS_STALL;
                  mode_next[0][3:0] = `UEM_M_STALLIO; // [RULE7]
                  irq_next[0] = 1'b1;
               end
               `UEM_M_ACKIN_STOUT, `UEM_M_ACKOUT_STIN, `UEM_M_STIN: begin
                  resp_next.hs = UEM_HS_DATA;
                  resp_next.toggle = curCnt[`UEM_CNT_TOG];
                  resp_next.count = (mode == `UEM_M_ACKIN_STOUT) ?
                     curCnt[3:0] : 4'h0; // [RULE4] [RULE9]
                  pendValid_next = 1'b1;
                  pendEp_next = 2'd0;
               end
               default: resp_next.hs = UEM_HS_NONE;
            endcase
            resp_next.valid = resp_next.hs != UEM_HS_NONE;
         end else if (isOut && ctrlOk) begin
            case (mode)
               `UEM_M_STALLIO: resp_next.hs = UEM_HS_STALL; // [RULE2]
               `UEM_M_NAKIO: resp_next.hs = UEM_HS_NAK; // [RULE3]
               `UEM_M_ACKIN_STOUT, `UEM_M_STOUT: begin
                  irq_next[0] = 1'b1;
                  if (goodStatus) begin // [RULE20]
                     resp_next.hs = UEM_HS_ACK;
                     mode_next[0][`UEM_MODE_OUT] = 1'b1;
                     mode_next[0][`UEM_MODE_ACKD] = 1'b1;
                     cnt_next[0] = {2'b11, 2'b00, `UEM_STATUS_LEN};
                     if (mode == `UEM_M_ACKIN_STOUT) begin
                        mode_next[0][3:0] = `UEM_M_STOUT; // [RULE5]
                     end // Mode 0010 keeps its mode. [RULE8]
                  end else begin
                     resp_next.hs = UEM_HS_STALL;
                     mode_next[0][3:0] = `UEM_M_STALLIO; // [RULE6]
                  end
               end
               `UEM_M_ACKOUT_STIN: begin
                  resp_next.hs = UEM_HS_ACK;
                  mode_next[0][`UEM_MODE_OUT] = 1'b1;
                  mode_next[0][`UEM_MODE_ACKD] = 1'b1;
                  mode_next[0][3:0] = `UEM_M_NAKIO; // [RULE10]
                  cnt_next[0] = cntUpd;
                  irq_next[0] = 1'b1;
               end
               `UEM_M_STIN: begin
                  resp_next.hs = UEM_HS_STALL;
                  mode_next[0][3:0] = `UEM_M_STALLIO; // [RULE11]
                  irq_next[0] = 1'b1;
               end
               default: resp_next.hs = UEM_HS_NONE;
            endcase
            resp_next.valid = resp_next.hs != UEM_HS_NONE;
         end
      end else if (tokIn.valid && epOk && ep != 2'd0) begin
         if (isOut && dataLenOk) begin // [RULE12]
            case (mode)
               `UEM_M_ACKOUT: begin
                  if (stallBit) begin
                     resp_next.hs = UEM_HS_STALL; // [RULE14]
                  end else begin
                     resp_next.hs = UEM_HS_ACK;
                     mode_next[ep][`UEM_MODE_ACKD] = 1'b1;
                     mode_next[ep][3:0] = `UEM_M_NAKOUT; // [RULE13]
                     cnt_next[ep] = cntUpd;
                     irq_next[ep] = 1'b1;
                  end
               end
               `UEM_M_NAKOUT: begin
                  resp_next.hs = UEM_HS_NAK;
                  irq_next[ep] = nakIe; // [RULE15]
               end
               default: resp_next.hs = UEM_HS_NONE; // [RULE17]
            endcase
         end else if (isIn) begin
            case (mode)
               `UEM_M_ACKIN: begin
                  if (stallBit) begin
                     resp_next.hs = UEM_HS_STALL; // [RULE17]
                  end else begin
                     resp_next.hs = UEM_HS_DATA; // [RULE16]
                     resp_next.count = curCnt[3:0];
                     resp_next.toggle = curCnt[`UEM_CNT_TOG];
                     pendValid_next = 1'b1;
                     pendEp_next = ep;
                  end
               end
               `UEM_M_NAKIN: begin
                  resp_next.hs = UEM_HS_NAK;
                  irq_next[ep] = nakIe; // [RULE15]
               end
               default: resp_next.hs = UEM_HS_NONE;
            endcase
         end
         resp_next.valid = resp_next.hs != UEM_HS_NONE;
      end
   end

   // ==========================================================
   // Firmware register writes; engine updates win over them.
   wire logic engMode [3];
   wire logic engCnt [3];
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : gEp
         assign engMode[g] = mode_next[g] != mode_reg[g];
         assign engCnt[g] = cnt_next[g] != cnt_reg[g];
         always_ff @(posedge clk or negedge rstN_reg) begin
            if (!rstN_reg) begin
               mode_reg[g] <= `UEM_REG_RESET;
               cnt_reg[g] <= `UEM_REG_RESET;
            end else begin
               if (engMode[g]) begin
                  mode_reg[g] <= mode_next[g];
               end else if (regWr && regAddr == `UEM_ADDR_MODE0 + 8'(g)) begin
                  mode_reg[g] <= (g == 0) ? {4'h0, regWdata[3:0]} :
                     {regWdata[7:5], mode_reg[g][4] & ~1'b1,
                     regWdata[3:0]}; // [RULE19]
               end
               if (engCnt[g]) begin
                  cnt_reg[g] <= cnt_next[g];
               end else if (regWr && regAddr == `UEM_ADDR_CNT0 + 8'(g)) begin
                  cnt_reg[g] <= {regWdata[7:6], 2'b00, regWdata[3:0]};
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (bufWrEn) begin
         buf_reg[byteIn.valid ? tokIn.endp : 2'd0][byteIn.index] <=
            byteIn.data;
      end else if (regWr && fwBufHit) begin
         buf_reg[fwBufEp][fwBufOff[2:0]] <= regWdata;
      end
   end

   // ==========================================================
   // Read mux and outputs
   wire logic [7:0] rdMux =
      regAddr == `UEM_ADDR_ENABLE ? enable_reg :
      (regAddr >= `UEM_ADDR_CNT0 && regAddr <= `UEM_ADDR_CNT2) ?
         cnt_reg[2'(regAddr - `UEM_ADDR_CNT0)] :
      (regAddr >= `UEM_ADDR_MODE0 && regAddr <= `UEM_ADDR_MODE2) ?
         mode_reg[2'(regAddr - `UEM_ADDR_MODE0)] & 8'hBF | 
         (regAddr == `UEM_ADDR_MODE0 ? mode_reg[0] & 8'h40 : 8'h00) :
      fwBufHit ? buf_reg[fwBufEp][fwBufOff[2:0]] : 8'h00;

   always_ff @(posedge clk or negedge rstN_reg) begin
      if (!rstN_reg) begin
         enable_reg <= `UEM_REG_RESET;
         regRdata <= 8'h00;
         respOut <= '0;
         epIrq <= 3'b000;
         usbEnable <= 1'b0;
         devAddr <= 7'h00;
         pendValid_reg <= 1'b0;
         pendEp_reg <= 2'd0;
      end else begin
         if (regWr && regAddr == `UEM_ADDR_ENABLE) begin
            enable_reg <= regWdata;
         end
         regRdata <= regRd ? rdMux : 8'h00;
         respOut <= resp_next;
         epIrq <= irq_next;
         usbEnable <= enable_reg[7];
         devAddr <= enable_reg[6:0];
         pendValid_reg <= pendValid_next;
         pendEp_reg <= pendEp_next;
      end
   end

   // ==========================================================
   // Checks
   AST_SETUP_ACK: assert property ( // [RULE1]
      @(posedge clk) disable iff (!rstN_reg)
      isSetup && ctrlOk && ep == 2'd0 && mode != 4'h0 |=>
      respOut.hs == UEM_HS_ACK && mode_reg[0][3:0] == 4'h1 && epIrq[0])
      else $error("setup not acked");
   AST_STALL_MODE: assert property ( // [RULE2]
      @(posedge clk) disable iff (!rstN_reg)
      isIn && ep == 2'd0 && mode == 4'h3 |=>
      respOut.hs == UEM_HS_STALL && $stable(mode_reg[0]))
      else $error("stall mode wrong");
   AST_NAK_MODE: assert property ( // [RULE3]
      @(posedge clk) disable iff (!rstN_reg)
      isIn && ep == 2'd0 && mode == 4'h1 |=>
      respOut.hs == UEM_HS_NAK && !epIrq[0])
      else $error("nak mode wrong");
   AST_STATUS_IN_STALL: assert property ( // [RULE7]
      @(posedge clk) disable iff (!rstN_reg)
      isIn && ep == 2'd0 && mode == 4'h2 |=>
      mode_reg[0][3:0] == 4'h3 && epIrq[0])
      else $error("status out in not stalled");
   AST_GOOD_STATUS: assert property ( // [RULE5]
      @(posedge clk) disable iff (!rstN_reg)
      isOut && ctrlOk && goodStatus && ep == 2'd0 && mode == 4'hF |=>
      mode_reg[0][3:0] == 4'h2 && cnt_reg[0] == 8'hC2)
      else $error("good status wrong");
   AST_BAD_STATUS: assert property ( // [RULE6]
      @(posedge clk) disable iff (!rstN_reg)
      isOut && ctrlOk && !goodStatus && ep == 2'd0 && mode == 4'h2 |=>
      respOut.hs == UEM_HS_STALL && mode_reg[0][3:0] == 4'h3)
      else $error("bad status wrong");
   AST_DATA_ACK: assert property ( // [RULE13]
      @(posedge clk) disable iff (!rstN_reg)
      isOut && dataLenOk && ep != 2'd0 && mode == 4'h9 && !stallBit |=>
      mode_reg[$past(ep)][3:0] == 4'h8)
      else $error("data out not acked");
   AST_DATA_BAD: assert property ( // [RULE12]
      @(posedge clk) disable iff (!rstN_reg)
      isOut && !dataLenOk && ep != 2'd0 && !(pendValid_reg && hostAck) |=>
      respOut.valid == 1'b0 && epIrq == 3'b000)
      else $error("bad data out answered");
endmodule

// File: uem_engine_tb.sv
/*
 Self-checking bench of the endpoint mode engine: firmware register port
 driven here, host traffic through the host model.
 Assumes the engine's constants header and package.
*/
`timescale 1ns/1ps
`include "uem_consts.svh"

module uem_engine_tb;
   import uem_pkg::*;
   logic clk, resetn, regWr, regRd, hostAck, usbEnable;
   logic [7:0] regAddr, regWdata, regRdata;
   logic [6:0] devAddr;
   logic [2:0] epIrq;
   uem_tok_s tokIn;
   uem_byte_s byteIn;
   uem_resp_s respOut, lastResp;
   int badCount, checksDone, cycles, m;

   uem_engine #(.MAX_DATA(8)) uut (.clk(clk), .resetn(resetn),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .tokIn(tokIn), .byteIn(byteIn),
      .hostAck(hostAck), .respOut(respOut), .usbEnable(usbEnable),
      .devAddr(devAddr), .epIrq(epIrq));
   uem_host_model host (.clk(clk), .tokIn(tokIn), .byteIn(byteIn),
      .hostAck(hostAck), .respOut(respOut), .epIrq(epIrq));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // =========================================================
   // Reporting
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checksDone, badCount);
      if (badCount == 0 && checksDone > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checksDone++;
      if (got !== exp) begin
         badCount++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chkHs(input uem_hs_e got, input uem_hs_e exp);
      checksDone++;
      if (got !== exp) begin
         badCount++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Ceiling is far above the few hundred cycles the run needs.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         badCount++;
         finish_test();
      end
   end

   // =========================================================
   // Register port and traffic helpers
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] msk,
      input logic [7:0] e);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      @(negedge clk);
      chk8(regRdata & msk, e);
   endtask

   // okTog holds the packet's good flag and its data toggle.
   task automatic tx(input uem_token_e k, input logic [1:0] ep,
      input logic [3:0] cnt, input logic [1:0] okTog, input logic ack,
      input uem_hs_e eh, input logic [2:0] ei);
      logic [2:0] irq;
      host.xfer(k, ep, cnt, okTog[1], okTog[0], ack, lastResp, irq);
      chkHs(lastResp.hs, eh);
      chk8({7'h0, lastResp.valid}, {7'h0, eh != UEM_HS_NONE});
      chk8({5'h0, irq}, {5'h0, ei});
   endtask

   // =========================================================
   // Scenarios
   task automatic scReset();
      for (m = 8'h40; m <= 8'h46; m++) begin
         rd(8'(m), 8'hFF, 8'h00);
      end
      rd(8'h70, 8'hFF, 8'h00);
      wr(`UEM_ADDR_ENABLE, 8'h85);
      repeat (2) @(negedge clk);
      chk8({usbEnable, devAddr}, 8'h85);
      tx(UEM_TOK_IN, 2'd0, 4'd0, 2'b10, 1'b0, UEM_HS_NONE, 3'b000);
   endtask

   task automatic scSetup();
      wr(`UEM_ADDR_MODE0, 8'h03);
      tx(UEM_TOK_SETUP, 2'd0, 4'd11, 2'b10, 1'b0, UEM_HS_NONE, 3'b000);
      tx(UEM_TOK_SETUP, 2'd0, 4'd3, 2'b10, 1'b0, UEM_HS_ACK, 3'b001);
      rd(`UEM_ADDR_MODE0, 8'hFF, 8'h91);
      rd(`UEM_ADDR_CNT0, 8'h4F, 8'h43);
      rd(`UEM_ADDR_BUF0 + 8'h02, 8'hFF, 8'hA2);
      wr(`UEM_ADDR_MODE0, 8'hF3);
      rd(`UEM_ADDR_MODE0, 8'hFF, 8'h03);
   endtask

   task automatic scStallNak();
      uem_hs_e hs;
      wr(`UEM_ADDR_CNT0, 8'h85);
      for (m = 0; m < 2; m++) begin
         hs = (m == 0) ? UEM_HS_STALL : UEM_HS_NAK;
         wr(`UEM_ADDR_MODE0, (m == 0) ? 8'h03 : 8'h01);
         tx(UEM_TOK_IN, 2'd0, 4'd0, 2'b10, 1'b0, hs, 3'b000);
         tx(UEM_TOK_OUT, 2'd0, 4'd2, 2'b11, 1'b0, hs, 3'b000);
         rd(`UEM_ADDR_MODE0, 8'hFF, (m == 0) ? 8'h03 : 8'h01);
         rd(`UEM_ADDR_CNT0, 8'hFF, 8'h85);
      end
   endtask

   task automatic scAckIn();
      wr(`UEM_ADDR_CNT0, 8'h83);
      wr(`UEM_ADDR_MODE0, 8'h0F);
      tx(UEM_TOK_IN, 2'd0, 4'd0, 2'b10, 1'b0, UEM_HS_DATA, 3'b000);
      rd(`UEM_ADDR_MODE0, 8'hFF, 8'h0F);
      tx(UEM_TOK_IN, 2'd0, 4'd0, 2'b10, 1'b1, UEM_HS_DATA, 3'b001);
      chk8({3'h0, lastResp.toggle, lastResp.count}, 8'h13);
      rd(`UEM_ADDR_MODE0, 8'hFF, 8'h51);
   endtask

   task automatic scStatusOut();
      wr(`UEM_ADDR_MODE0, 8'h0F);
      tx(UEM_TOK_OUT, 2'd0, 4'd2, 2'b01, 1'b0, UEM_HS_NONE, 3'b000);
      tx(UEM_TOK_OUT, 2'd0, 4'd2, 2'b11, 1'b0, UEM_HS_ACK, 3'b001);
      rd(`UEM_ADDR_MODE0, 8'hFF, 8'h32);
      rd(`UEM_ADDR_CNT0, 8'hFF, 8'hC2);
      tx(UEM_TOK_OUT, 2'd0, 4'd2, 2'b11, 1'b0, UEM_HS_ACK, 3'b001);
      rd(`UEM_ADDR_MODE0, 8'hFF, 8'h32);
      tx(UEM_TOK_OUT, 2'd0, 4'd2, 2'b10, 1'b0, UEM_HS_STALL, 3'b001);
      rd(`UEM_ADDR_MODE0, 8'h0F, 8'h03);
      wr(`UEM_ADDR_MODE0, 8'h0F);
      tx(UEM_TOK_OUT, 2'd0, 4'd3, 2'b11, 1'b0, UEM_HS_STALL, 3'b001);
      rd(`UEM_ADDR_MODE0, 8'h0F, 8'h03);
      wr(`UEM_ADDR_MODE0, 8'h02);
      tx(UEM_TOK_IN, 2'd0, 4'd0, 2'b10, 1'b0, UEM_HS_STALL, 3'b001);
      rd(`UEM_ADDR_MODE0, 8'h0F, 8'h03);
   endtask

   task automatic scStatusIn();
      for (m = 0; m < 2; m++) begin
         wr(`UEM_ADDR_MODE0, (m == 0) ? 8'h0B : 8'h06);
         tx(UEM_TOK_IN, 2'd0, 4'd0, 2'b10, 1'b1, UEM_HS_DATA, 3'b001);
         chk8({4'h0, lastResp.count}, 8'h00);
         rd(`UEM_ADDR_MODE0, 8'hFF, 8'h53);
      end
      wr(`UEM_ADDR_MODE0, 8'h0B);
      tx(UEM_TOK_OUT, 2'd0, 4'd4, 2'b11, 1'b0, UEM_HS_ACK, 3'b001);
      rd(`UEM_ADDR_MODE0, 8'hFF, 8'h31);
      rd(`UEM_ADDR_CNT0, 8'h4F, 8'h44);
      rd(`UEM_ADDR_BUF0 + 8'h03, 8'hFF, 8'hA3);
      wr(`UEM_ADDR_MODE0, 8'h06);
      tx(UEM_TOK_OUT, 2'd0, 4'd2, 2'b11, 1'b0, UEM_HS_STALL, 3'b001);
      rd(`UEM_ADDR_MODE0, 8'h0F, 8'h03);
   endtask

   task automatic scDataOut();
      wr(`UEM_ADDR_MODE1, 8'h09);
      tx(UEM_TOK_OUT, 2'd1, 4'd4, 2'b01, 1'b0, UEM_HS_NONE, 3'b000);
      tx(UEM_TOK_OUT, 2'd1, 4'd9, 2'b11, 1'b0, UEM_HS_NONE, 3'b000);
      rd(`UEM_ADDR_MODE1, 8'hFF, 8'h09);
      rd(`UEM_ADDR_CNT1, 8'hFF, 8'h00);
      tx(UEM_TOK_OUT, 2'd1, 4'd5, 2'b11, 1'b0, UEM_HS_ACK, 3'b010);
      rd(`UEM_ADDR_MODE1, 8'hFF, 8'h18);
      rd(`UEM_ADDR_CNT1, 8'h4F, 8'h45);
      rd(`UEM_ADDR_BUF1 + 8'h04, 8'hFF, 8'hA4);
      tx(UEM_TOK_OUT, 2'd1, 4'd2, 2'b11, 1'b0, UEM_HS_NAK, 3'b000);
      wr(`UEM_ADDR_MODE1, 8'h28);
      tx(UEM_TOK_OUT, 2'd1, 4'd2, 2'b11, 1'b0, UEM_HS_NAK, 3'b010);
      wr(`UEM_ADDR_MODE1, 8'h89);
      tx(UEM_TOK_OUT, 2'd1, 4'd2, 2'b11, 1'b0, UEM_HS_STALL, 3'b000);
      rd(`UEM_ADDR_MODE1, 8'hFF, 8'h89);
   endtask

   task automatic scDataIn();
      wr(`UEM_ADDR_CNT2, 8'h86);
      wr(`UEM_ADDR_MODE2, 8'h0D);
      tx(UEM_TOK_IN, 2'd2, 4'd0, 2'b10, 1'b1, UEM_HS_DATA, 3'b100);
      chk8({4'h0, lastResp.count}, 8'h06);
      rd(`UEM_ADDR_MODE2, 8'hFF, 8'h1C);
      tx(UEM_TOK_IN, 2'd2, 4'd0, 2'b10, 1'b0, UEM_HS_NAK, 3'b000);
      wr(`UEM_ADDR_MODE2, 8'h8D);
      tx(UEM_TOK_IN, 2'd2, 4'd0, 2'b10, 1'b0, UEM_HS_STALL, 3'b000);
      tx(UEM_TOK_OUT, 2'd2, 4'd2, 2'b11, 1'b0, UEM_HS_NONE, 3'b000);
      tx(UEM_TOK_IN, 2'd3, 4'd0, 2'b10, 1'b0, UEM_HS_NONE, 3'b000);
   endtask

   // =========================================================
   // Main sequence
   initial begin
      resetn = 1'b0;
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = 8'h00;
      regWdata = 8'h00;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      scReset();
      scSetup();
      scStallNak();
      scAckIn();
      scStatusOut();
      scStatusIn();
      scDataOut();
      scDataIn();
      finish_test();
   end
endmodule

// File: uem_host_model.sv
/*
 Behavioural low-speed host seen through the packet layer: sends data bytes,
 then the token summary, collects the handshake and may ACK sent data.
 Assumes the engine answers one cycle after it takes a token.
*/
`timescale 1ns/1ps

module uem_host_model (
   // Clock
   input wire logic clk,
   // Toward the engine
   output uem_pkg::uem_tok_s tokIn,
   output uem_pkg::uem_byte_s byteIn,
   output logic hostAck,
   // From the engine
   input wire uem_pkg::uem_resp_s respOut,
   input wire logic [2:0] epIrq
);
   import uem_pkg::*;

   initial begin
      tokIn = '0;
      byteIn = '{1'b0, 3'h0, 8'h5A};
      hostAck = 1'b0;
   end

   // =========================================================
   // One transaction
   // A released data lane shows the inverse of its last byte, so stale data
   // cannot pass for fresh data.
   task automatic xfer(input uem_token_e k, input logic [1:0] ep,
      input logic [3:0] cnt, input logic ok, input logic tog,
      input logic ack, output uem_resp_s r, output logic [2:0] irq);
      int i;
      // Bytes are filed under the endpoint on the token lane, so show it
      // before the first byte arrives.
      tokIn.endp <= ep;
      for (i = 0; i < cnt && i < 8 && k != UEM_TOK_IN; i++) begin
         @(posedge clk);
         byteIn <= '{1'b1, i[2:0], 8'hA0 + 8'(i)};
      end
      @(posedge clk);
      byteIn <= '{1'b0, 3'h0, ~byteIn.data};
      tokIn <= '{1'b1, k, ep, cnt, ok, tog};
      @(posedge clk);
      tokIn.valid <= 1'b0;
      @(negedge clk);
      r = respOut;
      irq = epIrq;
      if (ack && r.hs == UEM_HS_DATA) begin
         @(posedge clk);
         hostAck <= 1'b1;
         @(posedge clk);
         hostAck <= 1'b0;
         @(negedge clk);
         irq = irq | epIrq;
      end
   endtask
endmodule

// File: uem_pkg.sv
/*
 Types of the endpoint mode engine. Assumes nothing of its surroundings.
*/
package uem_pkg;
   typedef enum logic [1:0] {UEM_TOK_SETUP, UEM_TOK_IN, UEM_TOK_OUT}
      uem_token_e;
   typedef enum logic [2:0] {UEM_HS_NONE, UEM_HS_ACK, UEM_HS_NAK,
      UEM_HS_STALL, UEM_HS_DATA} uem_hs_e;
   // One decoded token or data packet from the packet layer.
   typedef struct packed {
      logic valid;
      uem_token_e kind;
      logic [1:0] endp;
      logic [3:0] count;
      logic dataOk;
      logic toggle;
   } uem_tok_s;
   // One received data byte.
   typedef struct packed {
      logic valid;
      logic [2:0] index;
      logic [7:0] data;
   } uem_byte_s;
   // Handshake decision to the packet layer.
   typedef struct packed {
      logic valid;
      uem_hs_e hs;
      logic [3:0] count;
      logic toggle;
   } uem_resp_s;
endpackage
